/* design/admd_consts.svh */
/*
 * Constants of the digital-microphone capture and dc-measurement block:
 * register offsets, field positions, reset values and filter scaling.
 * Assumes it is included by bare name from the package and the top module.
 */
`ifndef ADMD_CONSTS_SVH
`define ADMD_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADMD_REG_PIN_FUNC     8'h33
`define ADMD_REG_DC_CFG       8'h66
`define ADMD_REG_DC_CTRL      8'h67
`define ADMD_REG_RESULT_A     8'h68
`define ADMD_REG_RESULT_B     8'h69
`define ADMD_REG_RESULT_C     8'h6A

// ****************************************************************
// Reset values
// ****************************************************************
`define ADMD_RST_PIN_FUNC     8'h00
`define ADMD_RST_DC_CFG       8'h00
`define ADMD_RST_DC_CTRL      8'h00

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define ADMD_PIN_FUNC_MSB     5
`define ADMD_PIN_FUNC_LSB     2
`define ADMD_PIN_FUNC_MODCLK  4'hA
`define ADMD_CFG_ENABLE_BIT   7
`define ADMD_CFG_TYPE_BIT     5
`define ADMD_FIELD_MSB        4
`define ADMD_CTRL_LATCH_BIT   6
`define ADMD_CTRL_PERIOD_BIT  5

// ****************************************************************
// Filter scaling and limits
// ****************************************************************
`define ADMD_D_MIN            5'h01
`define ADMD_D_MAX            5'h14
`define ADMD_WINDOW_LEN       20
`define ADMD_ONE              23'h400000
`define ADMD_EXT_BITS         20

`endif

/* design/admd_pkg.sv */
/*
 * Types shared by the digital-microphone and dc-measurement block.
 * Assumes admd_consts.svh is on the include path.
 */
package admd_pkg;
    `include "admd_consts.svh"

    // Filter type selected by the configuration register.
    typedef enum logic {
        ADMD_MODE_AVG = 1'b0,
        ADMD_MODE_IIR = 1'b1
    } admd_mode_t;

    typedef logic [7:0]         admd_byte_t;
    typedef logic signed [23:0] admd_result_t;
endpackage : admd_pkg

/* design/admd_skid_buf.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset; all outputs are flops.
 */
module admd_skid_buf #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import admd_pkg::*;

    logic [WIDTH-1:0] skid_data;
    logic             skid_empty;

    assign in_ready = skid_empty;

    // The output word moves on when taken; a word arriving during a stall waits in the skid entry.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid  <= 1'b0;
            out_data   <= '0;
            skid_data  <= '0;
            skid_empty <= 1'b1;
        end else if (out_ready || !out_valid) begin
            if (!skid_empty) begin
                out_data   <= skid_data;
                out_valid  <= 1'b1;
                skid_empty <= 1'b1;
            end else begin
                out_valid <= in_valid;
                if (in_valid) begin
                    out_data <= in_data;
                end
            end
        end else if (in_valid && skid_empty) begin
            skid_data  <= in_data;
            skid_empty <= 1'b0;
        end
    end
endmodule // admd_skid_buf

/* design/admd_top.sv */
/*
 * Digital-microphone capture and dc-measurement engine of the mono ADC.
 * Assumes a byte-wide register port driven by the control interface, one
 * clock, and a synchronous active-low reset.
 */
`include "admd_consts.svh"

module admd_top (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire admd_pkg::admd_byte_t reg_wdata,
    input  wire logic             reg_rd,
    output admd_pkg::admd_byte_t  reg_rdata,
    output logic                  reg_rvalid,
    input  wire logic             pin_one_in,
    output logic                  pin_one_out,
    output logic                  pin_one_oe,
    input  wire logic             serial_data_in,
    output logic                  mic_valid,
    input  wire logic             mic_ready,
    output logic                  mic_bit,
    output logic                  mic_overrun
);
    import admd_pkg::*;

    // ****************************************************************
    // Registers and internal state
    // ****************************************************************
    admd_byte_t   pin_func;
    admd_byte_t   dc_cfg;
    admd_byte_t   dc_ctrl;
    admd_result_t hold;
    admd_result_t dc_result;
    admd_result_t avg_res;
    logic         modulator_clock;
    logic         cap_bit;
    logic         cap_valid;
    logic         buf_ready;
    logic         latch_prev;
    logic [`ADMD_WINDOW_LEN-1:0] window;
    logic signed [43:0]          acc;
    logic [31:0]                 period_cnt;

    logic         dmic_sel;
    logic         tick;
    logic         dc_en;
    admd_mode_t   mode;
    logic [4:0]   d_eff;
    logic         per_en;
    logic         per_clear;
    logic         latch_rise;
    logic [4:0]   ones;
    logic signed [6:0]  next_sum;
    logic signed [30:0] next_prod;
    logic signed [44:0] next_diff;
    logic signed [44:0] next_step;
    logic signed [43:0] x_iir;
    logic [31:0]        period_last;
    logic [22:0]        recip_tab [1:`ADMD_WINDOW_LEN];

    // ****************************************************************
    // Decoded controls
    // ****************************************************************
    // D outside 1..20 is clamped so the filters never divide by zero or overrun the window.
    assign dmic_sel   = (pin_func[`ADMD_PIN_FUNC_MSB:`ADMD_PIN_FUNC_LSB] == `ADMD_PIN_FUNC_MODCLK);
    assign tick       = dmic_sel && !modulator_clock;
    assign dc_en      = dc_cfg[`ADMD_CFG_ENABLE_BIT];
    assign mode       = admd_mode_t'(dc_cfg[`ADMD_CFG_TYPE_BIT]);
    assign d_eff      = (dc_cfg[`ADMD_FIELD_MSB:0] < `ADMD_D_MIN) ? `ADMD_D_MIN :
                        (dc_cfg[`ADMD_FIELD_MSB:0] > `ADMD_D_MAX) ? `ADMD_D_MAX :
                        dc_cfg[`ADMD_FIELD_MSB:0];
    assign per_en     = dc_ctrl[`ADMD_CTRL_PERIOD_BIT];
    assign latch_rise = dc_ctrl[`ADMD_CTRL_LATCH_BIT] && !latch_prev;

    // ****************************************************************
    // Register port
    // ****************************************************************
    // Writes to the three control registers; result registers ignore writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_func <= `ADMD_RST_PIN_FUNC;
            dc_cfg   <= `ADMD_RST_DC_CFG;
            dc_ctrl  <= `ADMD_RST_DC_CTRL;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `ADMD_REG_PIN_FUNC: pin_func <= reg_wdata;
                `ADMD_REG_DC_CFG:   dc_cfg   <= reg_wdata;
                `ADMD_REG_DC_CTRL:  dc_ctrl  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data appears one cycle after the read strobe; unmapped offsets read zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    `ADMD_REG_PIN_FUNC: reg_rdata <= pin_func;
                    `ADMD_REG_DC_CFG:   reg_rdata <= dc_cfg;
                    `ADMD_REG_DC_CTRL:  reg_rdata <= dc_ctrl;
                    `ADMD_REG_RESULT_A: reg_rdata <= hold[23:16];
                    `ADMD_REG_RESULT_B: reg_rdata <= hold[15:8];
                    `ADMD_REG_RESULT_C: reg_rdata <= hold[7:0];
                    default:            reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Modulator clock and multipurpose pin
    // ****************************************************************
    // The modulator clock is the system clock divided by two and leaves on the pin only in microphone mode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modulator_clock <= 1'b0;
            pin_one_out     <= 1'b0;
            pin_one_oe      <= 1'b0;
        end else begin
            modulator_clock <= dmic_sel ? !modulator_clock : 1'b0;
            pin_one_out     <= dmic_sel ? !modulator_clock : 1'b0;
            pin_one_oe      <= dmic_sel;
        end
    end

    // ****************************************************************
    // Microphone capture
    // ****************************************************************
    // The bit is taken at the edge on which the modulator clock rises, when it has settled.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_bit   <= 1'b0;
            cap_valid <= 1'b0;
        end else begin
            cap_valid <= tick;
            if (tick) begin
                cap_bit <= serial_data_in;
            end
        end
    end

    // A captured bit that finds the buffer full is lost and flagged; leaving microphone mode clears the flag.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mic_overrun <= 1'b0;
        end else if (cap_valid && !buf_ready) begin
            mic_overrun <= 1'b1;
        end else if (!dmic_sel) begin
            mic_overrun <= 1'b0;
        end
    end

    admd_skid_buf #(
        .WIDTH (1)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (cap_valid),
        .in_ready  (buf_ready),
        .in_data   (cap_bit),
        .out_valid (mic_valid),
        .out_ready (mic_ready),
        .out_data  (mic_bit)
    );

    // ****************************************************************
    // Periodic reset counter
    // ****************************************************************
    // Counts modulator periods and clears the filters after two to the power R of them.
    assign period_last = 32'((64'h1 << dc_ctrl[`ADMD_FIELD_MSB:0]) - 64'h1);
    assign per_clear   = per_en && cap_valid && (period_cnt == period_last);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_cnt <= 32'h0;
        end else if (!dc_en || !per_en || per_clear) begin
            period_cnt <= 32'h0;
        end else if (cap_valid) begin
            period_cnt <= period_cnt + 32'h1;
        end
    end

    // ****************************************************************
    // Mode A: sliding average over the last D bits
    // ****************************************************************
    // Reciprocals of the window length, so the average needs a multiply and no divider.
    for (genvar k = 1; k <= `ADMD_WINDOW_LEN; k++) begin : g_recip
        assign recip_tab[k] = 23'((32'(`ADMD_ONE) + 32'(k / 2)) / 32'(k));
    end

    // Counts the ones among the newest D bits and turns the count into a signed 2.22 mean.
    always_comb begin
        ones = 5'h00;
        for (int i = 0; i < `ADMD_WINDOW_LEN; i++) begin
            if (5'(i) < d_eff) begin
                ones = ones + {4'h0, window[i]};
            end
        end
        next_sum  = $signed({1'b0, ones, 1'b0}) - $signed({2'b00, d_eff});
        next_prod = next_sum * $signed({1'b0, recip_tab[d_eff]});
    end

    // Window and average step once per modulator period while enabled.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            window  <= '0;
            avg_res <= '0;
        end else if (!dc_en || per_clear) begin
            window  <= '0;
            avg_res <= '0;
        end else if (cap_valid) begin
            window  <= {window[`ADMD_WINDOW_LEN-2:0], cap_bit};
            avg_res <= next_prod[23:0];
        end
    end

    // ****************************************************************
    // Mode B: first-order IIR
    // ****************************************************************
    // Coefficient is two to the minus D, so each step of D roughly halves the bandwidth.
    assign x_iir     = cap_bit ? (44'(`ADMD_ONE) <<< `ADMD_EXT_BITS) : -(44'(`ADMD_ONE) <<< `ADMD_EXT_BITS);
    assign next_diff = {x_iir[43], x_iir} - {acc[43], acc};
    assign next_step = next_diff >>> d_eff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc <= '0;
        end else if (!dc_en || per_clear) begin
            acc <= '0;
        end else if (cap_valid && mode == ADMD_MODE_IIR) begin
            acc <= acc + next_step[43:0];
        end
    end

    // ****************************************************************
    // Result and latch
    // ****************************************************************
    // The live result follows the selected filter; the held copy is taken when the latch bit rises.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dc_result  <= '0;
            hold       <= '0;
            latch_prev <= 1'b0;
        end else begin
            latch_prev <= dc_ctrl[`ADMD_CTRL_LATCH_BIT];
            dc_result  <= (mode == ADMD_MODE_AVG) ? avg_res : acc[43:`ADMD_EXT_BITS];
            if (latch_rise) begin
                hold <= dc_result;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_latch_set;
        !latch_prev ##0 dc_ctrl[`ADMD_CTRL_LATCH_BIT];
    endsequence

    sequence s_latch_kept;
        latch_prev ##0 dc_ctrl[`ADMD_CTRL_LATCH_BIT];
    endsequence

    sequence s_result_read;
        reg_rd ##0 reg_addr == `ADMD_REG_RESULT_A;
    endsequence

    sequence s_cap_step;
        dc_en && !per_clear ##0 cap_valid;
    endsequence

    chk_pin_drive: assert property (@(posedge clk) disable iff (!rst_n)
        dmic_sel |=> pin_one_oe) else $error("Pin not driven in microphone mode.");
    chk_pin_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        pin_one_oe && $past(pin_one_oe) && dmic_sel |=> pin_one_out != $past(pin_one_out))
        else $error("Modulator clock stopped on the pin.");
    chk_mic_capture: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> cap_valid && cap_bit == $past(serial_data_in)) else $error("Microphone bit not captured.");
    chk_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !dc_en |=> window == '0 && acc == '0) else $error("Filters run while disabled.");
    chk_result_range: assert property (@(posedge clk) disable iff (!rst_n)
        avg_res <= $signed({1'b0, `ADMD_ONE}) && avg_res >= -$signed({1'b0, `ADMD_ONE}))
        else $error("Average outside the 2.22 range.");
    chk_latch_copy: assert property (@(posedge clk) disable iff (!rst_n)
        s_latch_set |=> hold == $past(dc_result)) else $error("Latch did not copy the result.");
    chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_latch_kept |=> $stable(hold)) else $error("Held result changed while latched.");
    chk_iir_rise: assert property (@(posedge clk) disable iff (!rst_n)
        dc_en && !per_clear && cap_valid && cap_bit && mode == ADMD_MODE_IIR |=> acc >= $past(acc))
        else $error("IIR fell on a one bit.");
    chk_period_clear: assert property (@(posedge clk) disable iff (!rst_n)
        per_clear |=> window == '0 && period_cnt == 32'h0) else $error("Periodic reset missed.");
    chk_no_period: assert property (@(posedge clk) disable iff (!rst_n)
        !per_en |-> !per_clear) else $error("Reset without the periodic bit.");
    chk_avg_count: assert property (@(posedge clk) disable iff (!rst_n)
        ones <= d_eff) else $error("Averaged more bits than D.");
    chk_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid) else $error("Read strobe got no answer.");
    chk_result_msb: assert property (@(posedge clk) disable iff (!rst_n)
        s_result_read |=> reg_rdata == $past(hold[23:16])) else $error("Upper result byte wrong.");
    chk_result_lsb: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `ADMD_REG_RESULT_C |=> reg_rdata == $past(hold[7:0]))
        else $error("Lower result byte wrong.");
    chk_window_shift: assert property (@(posedge clk) disable iff (!rst_n)
        s_cap_step |=> window[0] == $past(cap_bit)) else $error("Captured bit missing from window.");
    chk_avg_unit: assert property (@(posedge clk) disable iff (!rst_n)
        s_cap_step ##0 d_eff == 5'h01 |=>
        avg_res == ($past(window[0]) ? $signed({1'b0, `ADMD_ONE}) : -$signed({1'b0, `ADMD_ONE})))
        else $error("One-long average wrong.");
    chk_avg_select: assert property (@(posedge clk) disable iff (!rst_n)
        mode == ADMD_MODE_AVG |=> dc_result == $past(avg_res)) else $error("Average not selected.");
    chk_iir_select: assert property (@(posedge clk) disable iff (!rst_n)
        mode == ADMD_MODE_IIR |=> dc_result == $past(acc[43:`ADMD_EXT_BITS]))
        else $error("IIR output not selected.");
    chk_iir_idle: assert property (@(posedge clk) disable iff (!rst_n)
        dc_en && !per_clear && mode == ADMD_MODE_AVG |=> $stable(acc)) else $error("IIR moved in averaging mode.");
    chk_overrun_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        mic_overrun && dmic_sel |=> mic_overrun) else $error("Overrun flag lost in microphone mode.");
endmodule // admd_top

/* verif/admd_mic_model.sv */
/*
 * Behavioural single-bit digital microphone for the capture bench.
 * Assumes the modulator clock and its enable come from the block under test
 * and that clk is the block's own clock.
 */
// ****************************************************************
// Microphone model
// ****************************************************************
module admd_mic_model (
    input  wire logic       clk,
    input  wire logic       mod_clk,
    input  wire logic       clk_oe,
    input  wire logic [1:0] mode,
    output logic            bit_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic alt  = 1'b0;
    logic line = 1'b0;

    assign bit_out = line;

    // A new bit is launched as the modulator clock falls, so it is settled at
    // the next rise; with no clock the line wanders so no stale bit survives.
    always @(posedge clk) begin
        if (!clk_oe) begin
            line <= ~line;
        end else if (mod_clk) begin
            alt  <= ~alt;
            line <= (mode == 2'h2) ? alt : mode[0];
        end
    end
endmodule // admd_mic_model

/* verif/tb_admd_top.sv */
/*
 * Self-checking bench for the microphone capture and dc-measurement block.
 * Assumes the design package and the microphone model are compiled first.
 */
module tb_admd_top;
    timeunit 1ns;
    timeprecision 1ps;
    import admd_pkg::*;

    logic         clk       = 1'b0;
    logic         rst_n     = 1'b0;
    logic [7:0]   reg_addr  = 8'h00;
    logic         reg_wr    = 1'b0;
    admd_byte_t   reg_wdata = 8'h00;
    logic         reg_rd    = 1'b0;
    logic         mic_ready = 1'b1;
    logic [1:0]   mic_mode  = 2'h0;
    admd_byte_t   reg_rdata;
    logic         reg_rvalid;
    logic         pin_one_out;
    logic         pin_one_oe;
    logic         serial_data_in;
    logic         mic_valid;
    logic         mic_bit;
    logic         mic_overrun;
    int           n_fail    = 0;
    int           n_tests   = 0;

    // ****************************************************************
    // Clock, design and microphone
    // ****************************************************************
    always #4 clk = ~clk;

    admd_top admd_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pin_one_in(1'b0), .pin_one_out(pin_one_out), .pin_one_oe(pin_one_oe),
        .serial_data_in(serial_data_in), .mic_valid(mic_valid), .mic_ready(mic_ready),
        .mic_bit(mic_bit), .mic_overrun(mic_overrun));

    admd_mic_model admd_mic_model_i (.clk(clk), .mod_clk(pin_one_out), .clk_oe(pin_one_oe),
        .mode(mic_mode), .bit_out(serial_data_in));

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    // Compares two values and reports a mismatch at once.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle write strobe, launched at a falling edge.
    task automatic wr(input logic [7:0] a, input admd_byte_t d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask

    // One-cycle read strobe; the answer must stand one cycle later.
    task automatic rd(input logic [7:0] a, output admd_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        chk({23'h0, reg_rvalid}, 24'h1);
        d = reg_rdata;
    endtask

    // Reads the three result bytes, most significant first.
    task automatic rd_res(output admd_result_t r);
        admd_byte_t x;
        rd(8'h68, x);
        r[23:16] = x;
        rd(8'h69, x);
        r[15:8] = x;
        rd(8'h6A, x);
        r[7:0] = x;
    endtask

    // Pulses the latch bit over the given control value, then reads back.
    task automatic latch(input admd_byte_t ctl, output admd_result_t r);
        wr(8'h67, ctl | 8'h40);
        wr(8'h67, ctl);
        rd_res(r);
    endtask

    task automatic close_out;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Cuts a hang short.
    initial begin
        #400000;
        n_fail++;
        close_out();
    end

    // Main sequence of register calls and expected values.
    initial begin
        logic [7:0]   addrs [7] = '{8'h33, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h70};
        int           dl [3]    = '{1, 3, 20};
        admd_byte_t   b;
        admd_result_t res;
        admd_result_t iv [2];
        logic         prev;
        int           n;
        int           k;
        int           e;
        wait_clk(4);
        rst_n = 1'b1;
        foreach (addrs[i]) begin
            rd(addrs[i], b);
            chk(b, 24'h0);
        end
        wr(8'h69, 8'hFF);
        rd(8'h69, b);
        chk(b, 24'h0);
        wr(8'h66, 8'h35);
        rd(8'h66, b);
        chk(b, 24'h35);
        wr(8'h33, 8'h14);
        wait_clk(2);
        chk({23'h0, pin_one_oe}, 24'h0);
        chk({23'h0, pin_one_out}, 24'h0);
        wr(8'h33, 8'h28);
        wait_clk(2);
        chk({23'h0, pin_one_oe}, 24'h1);
        prev = pin_one_out;
        wait_clk(1);
        chk({23'h0, pin_one_out}, {23'h0, ~prev});
        // Alternating bits must arrive alternating: no sample lost or doubled.
        mic_mode = 2'h2;
        n = 0;
        k = 0;
        while (n < 10 && k < 200) begin
            @(negedge clk);
            k++;
            if (mic_valid === 1'b1) begin
                if (n > 1) chk({23'h0, mic_bit}, {23'h0, ~prev});
                prev = mic_bit;
                n++;
            end
        end
        chk(n[23:0], 24'd10);
        // Measurement disabled: the filters never ran.
        latch(8'h00, res);
        chk(res, 24'h0);
        // Stalled consumer: buffer fills, a later bit is refused.
        mic_ready = 1'b0;
        wait_clk(12);
        chk({23'h0, mic_overrun}, 24'h1);
        chk({23'h0, mic_valid}, 24'h1);
        mic_ready = 1'b1;
        wr(8'h33, 8'h00);
        wait_clk(6);
        chk({23'h0, mic_overrun}, 24'h0);
        chk({23'h0, mic_valid}, 24'h0);
        // Averaging of a steady +1 stream for several lengths.
        wr(8'h33, 8'h28);
        mic_mode = 2'h1;
        foreach (dl[i]) begin
            wr(8'h66, {3'b100, dl[i][4:0]});
            wait_clk(100);
            latch(8'h00, res);
            e = dl[i] * ((32'h400000 + dl[i] / 2) / dl[i]);
            chk(res, e[23:0]);
        end
        // The held copy stays put until the next latch.
        mic_mode = 2'h0;
        wait_clk(100);
        rd_res(res);
        chk(res, e[23:0]);
        latch(8'h00, res);
        e = -e;
        chk(res, e[23:0]);
        // Clearing every 4 periods with D of 1 shows at some latch phase; a latch is 10 clocks, the period 8.
        wr(8'h66, 8'h81);
        mic_mode = 2'h1;
        wr(8'h67, 8'h22);
        wait_clk(100);
        n = 0;
        for (int i = 0; i < 4; i++) begin
            latch(8'h22, res);
            if (res !== 24'h400000) n++;
        end
        chk({23'h0, n > 0}, 24'h1);
        // Without the periodic bit a steady one stream reads one at every phase.
        wr(8'h67, 8'h00);
        wait_clk(100);
        for (int i = 0; i < 4; i++) begin
            latch(8'h00, res);
            chk(res, 24'h400000);
        end
        // IIR step response: a short coefficient settles faster.
        for (int i = 0; i < 2; i++) begin
            wr(8'h66, (i == 0) ? 8'hA1 : 8'hA4);
            mic_mode = 2'h0;
            wait_clk(200);
            mic_mode = 2'h1;
            wait_clk(32);
            latch(8'h00, iv[i]);
        end
        chk({23'h0, iv[0] > 24'sh3F0000}, 24'h1);
        chk({23'h0, iv[0] > iv[1]}, 24'h1);
        close_out();
    end
endmodule // tb_admd_top
